// [inc/rbc_pkg.sv]
package rbc_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_CONTROL_ONE = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_RX_START = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'hC;
   localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 4'h2;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CNT_LSB = 16;
   localparam int CNT_W = 8;
   localparam int MODULE_ACTIVE_BIT = 7;
   localparam int TRANSMIT_ACTIVE_BIT = 6;
   localparam int RECEIVE_ACTIVE_BIT = 5;
   localparam int MODULE_ON_BIT = 15;
   localparam int FLOW_CTRL_BIT = 1;
   localparam int DECREMENT_BIT = 0;
   localparam int PKT_PEND_BIT = 0;

   // ----------------------------------------------------------------
   // Values
   // ----------------------------------------------------------------
   localparam logic [CNT_W-1:0] CNT_FULL = 8'hFF;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   // Bus request carried as one bundle.
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } rbc_req_t;

   // Activity state of the module.
   typedef enum logic [1:0] {
      RBC_OFF = 2'b00,
      RBC_ON = 2'b01,
      RBC_DRAIN = 2'b11
   } rbc_state_t;

endpackage : rbc_pkg

// [core/rbc_counter.sv]
`timescale 1ns/100ps
`default_nettype none

module rbc_counter
   import rbc_pkg::*;
#(
   parameter int W = CNT_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Count events
   input wire logic clear,
   input wire logic inc,
   input wire logic [W-1:0] inc_amount,
   input wire logic dec,
   // Count value
   output logic [W-1:0] count_q
);

   localparam logic [W-1:0] MAXV = {W{1'b1}};
   localparam logic [W:0] MAXW = {1'b0, MAXV};

   logic [W:0] sum;

   assign sum = {1'b0, count_q} + {1'b0, inc_amount};

   // Saturating count; a clear from a new start address wins over everything.
   always_ff @(posedge clk) begin
      if (sys_rst || clear) begin
         count_q <= '0;
      end else if (inc && dec) begin
         count_q <= count_q;
      end else if (inc) begin
         count_q <= (sum > MAXW) ? MAXV : sum[W-1:0];
      end else if (dec && count_q != '0) begin
         count_q <= count_q - 1'b1;
      end
   end

   a_cnt_no_wrap_up: assert property (@(posedge clk) disable iff (sys_rst)
      (count_q == MAXV && inc && !dec && !clear) |=> count_q == MAXV)
      else $error("count wrapped above full");
   a_cnt_no_wrap_dn: assert property (@(posedge clk) disable iff (sys_rst)
      (count_q == '0 && dec && !inc && !clear) |=> count_q == '0)
      else $error("count wrapped below zero");
   a_cnt_both_hold: assert property (@(posedge clk) disable iff (sys_rst)
      (inc && dec && !clear) |=> $stable(count_q))
      else $error("count moved on simultaneous inc and dec");
   a_cnt_dec_one: assert property (@(posedge clk) disable iff (sys_rst)
      (dec && !inc && !clear && count_q != '0) |=> count_q == $past(count_q) - 1'b1)
      else $error("decrement not by one");

endmodule : rbc_counter

`default_nettype wire

// [core/rbc_status.sv]
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - The status word holds an 8-bit receive buffer count in bits 23..16, raised per good packet by its descriptor count.
// - A hardware increment at 0xFF leaves the count at 0xFF.
// - A software decrement at zero leaves the count at zero.
// - Increment and decrement in the same cycle leave the count unchanged.
// - With flow control on, receive halts at 0xFF and resumes once a decrement brings it below 0xFF.
// - With flow control off, receive DMA keeps running while the count saturates at 0xFF.
// - A nonzero count sets the packet-pending flag, which interrupts only when its enable is set.
// - Any write to the receive start address register clears the count to zero.
// - Switching the module off does not clear the count, and decrements still work.
// - Module-active in bit 7 reads 1 while the module is on and 0 when idle.
// - After module-on is cleared, module-active stays 1 until the transfer in progress ends.
// - Transmit-active bit 6 follows only transmit and receive-active bit 5 only receive; both clear when off.
// - Status bits 31..24, 15..8 and 4..0 read zero and all fields reset to zero.
module rbc_status
   import rbc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata_q,
   // Receive DMA side
   input wire logic rx_pkt_done,
   input wire logic [CNT_W-1:0] rx_pkt_descs,
   input wire logic rx_frame_busy,
   input wire logic tx_frame_busy,
   output logic rx_halt_q,
   // Status outputs
   output logic module_on_q,
   output logic packet_pending_flag_q,
   output logic irq_q
);

   // ----------------------------------------------------------------
   // Request decode
   // ----------------------------------------------------------------
   rbc_req_t req;
   logic wr_ctl;
   logic wr_start;
   logic buffer_count_decrement;
   logic [CNT_W-1:0] rx_buffer_count;
   logic flow_ctrl_q;
   logic packet_pending_irq_enable_q;
   logic module_active_q;
   logic transmit_active_q;
   logic receive_active_q;
   logic pend_sticky_q;
   rbc_state_t state_q;
   rbc_state_t state_d;

   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
   assign wr_ctl = req.wr && req.addr == OFS_CONTROL_ONE;
   assign wr_start = req.wr && req.addr == OFS_RX_START;
   // The decrement bit is a strobe: it is never stored, so it always reads zero.
   assign buffer_count_decrement = wr_ctl && req.wdata[DECREMENT_BIT];

   // ----------------------------------------------------------------
   // Buffer count
   // ----------------------------------------------------------------
   // The count ignores module-on, so software can drain it after switch-off.
   rbc_counter #(
      .W(CNT_W)
   ) u_count (
      .clk(clk),
      .sys_rst(sys_rst),
      .clear(wr_start),
      .inc(rx_pkt_done),
      .inc_amount(rx_pkt_descs),
      .dec(buffer_count_decrement),
      .count_q(rx_buffer_count)
   );

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   // Module-on and flow control live in control register one.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         module_on_q <= 1'b0;
         flow_ctrl_q <= 1'b0;
      end else if (wr_ctl) begin
         module_on_q <= req.wdata[MODULE_ON_BIT];
         flow_ctrl_q <= req.wdata[FLOW_CTRL_BIT];
      end
   end

   // Interrupt enable register.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         packet_pending_irq_enable_q <= 1'b0;
      end else if (req.wr && req.addr == OFS_IRQ_ENABLE) begin
         packet_pending_irq_enable_q <= req.wdata[PKT_PEND_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Receive halt
   // ----------------------------------------------------------------
   // Halt looks at the registered count, so it trails the count by one cycle;
   // the receive DMA must tolerate one more packet completing at the edge.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rx_halt_q <= 1'b0;
      end else begin
         rx_halt_q <= flow_ctrl_q && rx_buffer_count == CNT_FULL;
      end
   end

   // ----------------------------------------------------------------
   // Activity state
   // ----------------------------------------------------------------
   // Switch-off waits in the drain state until both directions are quiet.
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         RBC_OFF: begin
            if (module_on_q) state_d = RBC_ON;
         end
         RBC_ON: begin
            if (!module_on_q) begin
               state_d = (rx_frame_busy || tx_frame_busy) ? RBC_DRAIN : RBC_OFF;
            end
         end
         RBC_DRAIN: begin
            if (module_on_q) state_d = RBC_ON;
            else if (!rx_frame_busy && !tx_frame_busy) state_d = RBC_OFF;
         end
         default: state_d = RBC_OFF;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= RBC_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   // Busy bits; direction bits are forced low while the module is off.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         module_active_q <= 1'b0;
         transmit_active_q <= 1'b0;
         receive_active_q <= 1'b0;
      end else begin
         module_active_q <= state_d != RBC_OFF;
         transmit_active_q <= module_on_q && tx_frame_busy;
         receive_active_q <= module_on_q && rx_frame_busy;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt
   // ----------------------------------------------------------------
   // Pending is a level from the count; the sticky copy is set on it and
   // cleared by writing one, with the set winning over the clear.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         packet_pending_flag_q <= 1'b0;
         pend_sticky_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         packet_pending_flag_q <= rx_buffer_count != CNT_ZERO;
         if (rx_buffer_count != CNT_ZERO) begin
            pend_sticky_q <= 1'b1;
         end else if (req.wr && req.addr == OFS_IRQ_STATUS && req.wdata[PKT_PEND_BIT]) begin
            pend_sticky_q <= 1'b0;
         end
         irq_q <= pend_sticky_q && packet_pending_irq_enable_q;
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   // Unmapped addresses and reads without a strobe return zero.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata_q <= WORD_ZERO;
      end else begin
         reg_rdata_q <= WORD_ZERO;
         if (req.rd) begin
            unique case (req.addr)
               OFS_STATUS: begin
                  reg_rdata_q[CNT_LSB +: CNT_W] <= rx_buffer_count;
                  reg_rdata_q[MODULE_ACTIVE_BIT] <= module_active_q;
                  reg_rdata_q[TRANSMIT_ACTIVE_BIT] <= transmit_active_q;
                  reg_rdata_q[RECEIVE_ACTIVE_BIT] <= receive_active_q;
               end
               OFS_CONTROL_ONE: begin
                  reg_rdata_q[MODULE_ON_BIT] <= module_on_q;
                  reg_rdata_q[FLOW_CTRL_BIT] <= flow_ctrl_q;
               end
               OFS_IRQ_STATUS: reg_rdata_q[PKT_PEND_BIT] <= pend_sticky_q;
               OFS_IRQ_ENABLE: reg_rdata_q[PKT_PEND_BIT] <= packet_pending_irq_enable_q;
               default: reg_rdata_q <= WORD_ZERO;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_halt_at_full: assert property (@(posedge clk) disable iff (sys_rst)
      (flow_ctrl_q && rx_buffer_count == CNT_FULL) |=> rx_halt_q)
      else $error("receive not halted at full count");
   a_no_halt_noflow: assert property (@(posedge clk) disable iff (sys_rst)
      !flow_ctrl_q |=> !rx_halt_q)
      else $error("halt without flow control");
   a_pend_follows: assert property (@(posedge clk) disable iff (sys_rst)
      (rx_buffer_count != CNT_ZERO) |=> packet_pending_flag_q)
      else $error("pending flag missing");
   a_irq_gated: assert property (@(posedge clk) disable iff (sys_rst)
      !packet_pending_irq_enable_q |=> !irq_q)
      else $error("interrupt without enable");
   a_start_clears: assert property (@(posedge clk) disable iff (sys_rst)
      wr_start |=> rx_buffer_count == CNT_ZERO)
      else $error("start write did not clear count");
   a_off_keeps_cnt: assert property (@(posedge clk) disable iff (sys_rst)
      (wr_ctl && !req.wdata[MODULE_ON_BIT] && !req.wdata[DECREMENT_BIT] && !rx_pkt_done)
      |=> $stable(rx_buffer_count))
      else $error("switch-off changed count");
   a_busy_drain: assert property (@(posedge clk) disable iff (sys_rst)
      (state_q == RBC_ON && !module_on_q && (rx_frame_busy || tx_frame_busy))
      |=> module_active_q)
      else $error("module went idle during transfer");
   a_dir_off_clear: assert property (@(posedge clk) disable iff (sys_rst)
      !module_on_q |=> !transmit_active_q && !receive_active_q)
      else $error("direction busy while off");
   a_rd_reserved: assert property (@(posedge clk) disable iff (sys_rst)
      (req.rd && req.addr == OFS_STATUS) |=> reg_rdata_q[31:24] == 8'h00
      && reg_rdata_q[15:8] == 8'h00 && reg_rdata_q[4:0] == 5'h00)
      else $error("reserved status bits nonzero");

   // Activity bits are checked one cycle after the state or busy input they follow.
   a_active_when_on: assert property (@(posedge clk) disable iff (sys_rst)
      module_on_q |=> module_active_q)
      else $error("module active missing while on");
   a_idle_when_off: assert property (@(posedge clk) disable iff (sys_rst)
      (state_q == RBC_OFF && !module_on_q) |=> !module_active_q)
      else $error("module active while idle");
   a_drain_holds: assert property (@(posedge clk) disable iff (sys_rst)
      (state_q == RBC_DRAIN && (rx_frame_busy || tx_frame_busy)) |=> module_active_q)
      else $error("drain dropped module active early");
   a_drain_exit: assert property (@(posedge clk) disable iff (sys_rst)
      (state_q == RBC_DRAIN && !module_on_q && !rx_frame_busy && !tx_frame_busy)
      |=> !module_active_q)
      else $error("module active stuck after drain");
   a_tx_follows: assert property (@(posedge clk) disable iff (sys_rst)
      (module_on_q && tx_frame_busy) |=> transmit_active_q)
      else $error("transmit active missing");
   a_rx_follows: assert property (@(posedge clk) disable iff (sys_rst)
      (module_on_q && rx_frame_busy) |=> receive_active_q)
      else $error("receive active missing");
   a_tx_quiet: assert property (@(posedge clk) disable iff (sys_rst)
      !tx_frame_busy |=> !transmit_active_q)
      else $error("transmit active without transmit");
   a_rx_quiet: assert property (@(posedge clk) disable iff (sys_rst)
      !rx_frame_busy |=> !receive_active_q)
      else $error("receive active without receive");

   // Halt, pending and interrupt must fall again, not only rise.
   a_halt_release: assert property (@(posedge clk) disable iff (sys_rst)
      (rx_buffer_count != CNT_FULL) |=> !rx_halt_q)
      else $error("halt held below full count");
   a_pend_clear: assert property (@(posedge clk) disable iff (sys_rst)
      (rx_buffer_count == CNT_ZERO) |=> !packet_pending_flag_q)
      else $error("pending flag with zero count");
   a_sticky_set: assert property (@(posedge clk) disable iff (sys_rst)
      (rx_buffer_count != CNT_ZERO) |=> pend_sticky_q)
      else $error("sticky pending not set");
   a_irq_raise: assert property (@(posedge clk) disable iff (sys_rst)
      (pend_sticky_q && packet_pending_irq_enable_q) |=> irq_q)
      else $error("enabled interrupt missing");
   a_irq_drop: assert property (@(posedge clk) disable iff (sys_rst)
      !pend_sticky_q |=> !irq_q)
      else $error("interrupt without pending");

   // The idle bus reads zero, so a stale word is never mistaken for read data.
   a_rd_count: assert property (@(posedge clk) disable iff (sys_rst)
      (req.rd && req.addr == OFS_STATUS)
      |=> reg_rdata_q[CNT_LSB +: CNT_W] == $past(rx_buffer_count))
      else $error("status read lost the count");
   a_rd_idle_zero: assert property (@(posedge clk) disable iff (sys_rst)
      !req.rd |=> reg_rdata_q == WORD_ZERO)
      else $error("read data without a read");
   a_rd_dec_zero: assert property (@(posedge clk) disable iff (sys_rst)
      (req.rd && req.addr == OFS_CONTROL_ONE) |=> !reg_rdata_q[DECREMENT_BIT])
      else $error("decrement strobe read back");

   // ----------------------------------------------------------------
   // Cover points
   // ----------------------------------------------------------------
   c_full_halt: cover property (@(posedge clk) disable iff (sys_rst) rx_halt_q ##1 !rx_halt_q);
   c_drain: cover property (@(posedge clk) disable iff (sys_rst) state_q == RBC_DRAIN);
   c_irq: cover property (@(posedge clk) disable iff (sys_rst) irq_q);
   c_collide: cover property (@(posedge clk) disable iff (sys_rst)
      rx_pkt_done && buffer_count_decrement);
   c_off_count: cover property (@(posedge clk) disable iff (sys_rst)
      !module_on_q && rx_buffer_count != CNT_ZERO);

endmodule : rbc_status

`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/100ps
`default_nettype none

module testbench;
   import rbc_pkg::*;

   // ----------------------------------------------------------------
   // Clock, reset and design ports
   // ----------------------------------------------------------------
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [ADDR_W-1:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata_q;
   logic rx_pkt_done = 1'b0;
   logic [CNT_W-1:0] rx_pkt_descs = 8'h00;
   logic rx_frame_busy = 1'b0;
   logic tx_frame_busy = 1'b0;
   logic rx_halt_q;
   logic module_on_q;
   logic packet_pending_flag_q;
   logic irq_q;
   int failures = 0;
   int compares = 0;
   logic [31:0] exp_q[$];
   logic rd_seen = 1'b0;
   logic [7:0] lfsr = 8'h60;
   logic [7:0] cnt;
   logic [8:0] sum;

   // The clock toggles every half period of 5 ns.
   always #5 clk = ~clk;

   rbc_status u_dut (
      .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
      .rx_pkt_done(rx_pkt_done), .rx_pkt_descs(rx_pkt_descs),
      .rx_frame_busy(rx_frame_busy), .tx_frame_busy(tx_frame_busy),
      .rx_halt_q(rx_halt_q), .module_on_q(module_on_q),
      .packet_pending_flag_q(packet_pending_flag_q), .irq_q(irq_q)
   );

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_word

   task automatic cmp_flag(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_flag

   task automatic report_and_stop;
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : report_and_stop

   function automatic logic [31:0] stat(input logic [7:0] c, input logic a, input logic t,
                                        input logic r);
      return {8'h00, c, 8'h00, a, t, r, 5'h00};
   endfunction : stat

   // Eight-bit maximal-length shift register; the seed stands where lfsr is declared.
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr_next

   // Read data stands only in the cycle after the strobe, so the monitor looks exactly there.
   always @(posedge clk) begin
      if (rd_seen) begin
         cmp_word(reg_rdata_q, exp_q.pop_front());
      end
      rd_seen <= reg_rd;
   end

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask : rd

   // A packet may land together with a decrement write to test the collision case.
   task automatic pkt(input logic [7:0] n, input logic with_dec);
      @(posedge clk);
      rx_pkt_descs <= n;
      rx_pkt_done <= 1'b1;
      reg_addr <= OFS_CONTROL_ONE;
      reg_wdata <= 32'h0000_8001;
      reg_wr <= with_dec;
      @(posedge clk);
      rx_pkt_done <= 1'b0;
      reg_wr <= 1'b0;
   endtask : pkt

   // Waits are taken a little past the edge so registered flags have settled.
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : idle

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      rd(OFS_STATUS, WORD_ZERO);
      rd(OFS_CONTROL_ONE, WORD_ZERO);
      rd(OFS_IRQ_STATUS, WORD_ZERO);
      rd(4'h6, WORD_ZERO);
      $display("test reset done");
      wr(OFS_CONTROL_ONE, 32'h0000_8000);
      idle(2);
      cmp_flag(module_on_q, 1'b1);
      rd(OFS_STATUS, stat(8'h00, 1'b1, 1'b0, 1'b0));
      tx_frame_busy <= 1'b1;
      idle(3);
      rd(OFS_STATUS, stat(8'h00, 1'b1, 1'b1, 1'b0));
      tx_frame_busy <= 1'b0;
      rx_frame_busy <= 1'b1;
      idle(3);
      rd(OFS_STATUS, stat(8'h00, 1'b1, 1'b0, 1'b1));
      $display("test activity done");
      pkt(8'h03, 1'b0);
      rd(OFS_STATUS, stat(8'h03, 1'b1, 1'b0, 1'b1));
      cmp_flag(packet_pending_flag_q, 1'b1);
      wr(OFS_CONTROL_ONE, 32'h0000_8001);
      rd(OFS_STATUS, stat(8'h02, 1'b1, 1'b0, 1'b1));
      pkt(8'h05, 1'b1);
      rd(OFS_STATUS, stat(8'h02, 1'b1, 1'b0, 1'b1));
      wr(OFS_CONTROL_ONE, 32'h0000_0000);
      rd(OFS_STATUS, stat(8'h02, 1'b1, 1'b0, 1'b0));
      rx_frame_busy <= 1'b0;
      idle(3);
      rd(OFS_STATUS, stat(8'h02, 1'b0, 1'b0, 1'b0));
      wr(OFS_CONTROL_ONE, 32'h0000_0001);
      rd(OFS_STATUS, stat(8'h01, 1'b0, 1'b0, 1'b0));
      $display("test count done");
      wr(OFS_IRQ_ENABLE, 32'h0000_0001);
      idle(3);
      cmp_flag(irq_q, 1'b1);
      rd(OFS_IRQ_ENABLE, 32'h0000_0001);
      wr(OFS_IRQ_ENABLE, 32'h0000_0000);
      idle(3);
      cmp_flag(irq_q, 1'b0);
      wr(OFS_IRQ_ENABLE, 32'h0000_0001);
      wr(OFS_CONTROL_ONE, 32'h0000_0001);
      wr(OFS_IRQ_STATUS, 32'h0000_0001);
      idle(3);
      cmp_flag(irq_q, 1'b0);
      cmp_flag(packet_pending_flag_q, 1'b0);
      rd(OFS_IRQ_STATUS, WORD_ZERO);
      $display("test interrupt done");
      wr(OFS_CONTROL_ONE, 32'h0000_8002);
      pkt(8'hF0, 1'b0);
      pkt(8'h20, 1'b0);
      idle(3);
      rd(OFS_STATUS, stat(8'hFF, 1'b1, 1'b0, 1'b0));
      cmp_flag(rx_halt_q, 1'b1);
      wr(OFS_CONTROL_ONE, 32'h0000_8003);
      idle(3);
      cmp_flag(rx_halt_q, 1'b0);
      rd(OFS_STATUS, stat(8'hFE, 1'b1, 1'b0, 1'b0));
      rd(OFS_CONTROL_ONE, 32'h0000_8002);
      wr(OFS_CONTROL_ONE, 32'h0000_8000);
      pkt(8'h05, 1'b0);
      idle(3);
      cmp_flag(rx_halt_q, 1'b0);
      rd(OFS_STATUS, stat(8'hFF, 1'b1, 1'b0, 1'b0));
      $display("test saturation done");
      wr(OFS_RX_START, 32'h1234_5678);
      rd(OFS_STATUS, stat(8'h00, 1'b1, 1'b0, 1'b0));
      rd(OFS_RX_START, WORD_ZERO);
      wr(OFS_CONTROL_ONE, 32'h0000_8001);
      rd(OFS_STATUS, stat(8'h00, 1'b1, 1'b0, 1'b0));
      $display("test clear done");
      // Random mix of packets and decrements against a saturating model count.
      cnt = 8'h00;
      repeat (40) begin
         lfsr = lfsr_next(lfsr);
         if (lfsr[0]) begin
            pkt({2'b00, lfsr[6:1]}, 1'b0);
            sum = {1'b0, cnt} + {3'b000, lfsr[6:1]};
            cnt = sum[8] ? 8'hFF : sum[7:0];
         end else begin
            wr(OFS_CONTROL_ONE, 32'h0000_8001);
            cnt = (cnt == 8'h00) ? 8'h00 : cnt - 8'h01;
         end
         rd(OFS_STATUS, stat(cnt, 1'b1, 1'b0, 1'b0));
      end
      $display("test random done");
      idle(4);
      report_and_stop();
   end

   // A hang is cut short at 20000 cycles, well beyond the few hundred cycles the tests need.
   initial begin
      #200000;
      failures++;
      report_and_stop();
   end

endmodule : testbench

`default_nettype wire
